//--- core/tx_symbol_source_scrambler.sv
// Purpose: transmit symbol source selector, scrambler and quat mapper
// Assumes: i_sym_en is a one-cycle pulse per symbol; all inputs synchronous to i_clk
// Notes: one quat per symbol enable, presented one cycle after the enable
`default_nettype none
module tx_symbol_source_scrambler #(
	parameter int LEN = tx_src_pkg::LFSR_LEN
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_sym_en,
	input wire logic i_cu_sign,
	input wire logic i_cu_mag,
	input wire logic i_det_sign,
	input wire logic i_det_mag,
	input wire logic i_meter_tick,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	output logic [2:0] o_quat,
	output logic o_quat_valid
);
	import tx_src_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [7:0] mode_reg;
		logic [LEN-1:0] lfsr;
		logic pulse_pending;
		logic [2:0] quat;
		logic quat_valid;
		logic [7:0] rdata;
	} state_t;

	state_t cur;
	state_t next_st;

	logic [2:0] src;
	logic tx_off;
	logic poly_remote;
	logic [1:0] iso_level;
	logic scr_in_a;
	logic scr_in_b;
	logic scr_out_a;
	logic scr_out_b;
	logic [LEN-1:0] lfsr_one;
	logic [LEN-1:0] lfsr_two;

	assign src = cur.mode_reg[SRC_MSB:SRC_LSB];
	assign tx_off = cur.mode_reg[OFF_BIT];
	assign poly_remote = cur.mode_reg[POLY_BIT];
	assign iso_level = cur.mode_reg[ISO_MSB:ISO_LSB];

	// ************************************************************
	// scrambler input select
	// ************************************************************
	always_comb begin
		case (src)
			SRC_LOOP_SCR: begin
				scr_in_a = i_det_sign;
				scr_in_b = i_det_mag;
			end
			SRC_CU_SCR: begin
				scr_in_a = i_cu_sign;
				scr_in_b = i_cu_mag;
			end
			default: begin
				scr_in_a = 1'b1;
				scr_in_b = 1'b1;
			end
		endcase
	end

	tx_scrambler_lfsr #(
		.LEN(LEN)
	) u_lfsr (
		.i_state(cur.lfsr),
		.i_remote(poly_remote),
		.i_bit_a(scr_in_a),
		.i_bit_b(scr_in_b),
		.o_out_a(scr_out_a),
		.o_out_b(scr_out_b),
		.o_state_one(lfsr_one),
		.o_state_two(lfsr_two)
	);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_st = cur;
		next_st.quat_valid = i_sym_en;
		if (i_reg_wr && i_reg_addr == TX_MODE_CONTROL_ADDR) begin
			next_st.mode_reg = i_reg_wdata & TX_MODE_CONTROL_WMASK;
		end
		// rdata follows the address so a read sees state one cycle later
		next_st.rdata = (i_reg_addr == TX_MODE_CONTROL_ADDR) ? cur.mode_reg : 8'h00;
		// tick is sticky until the next symbol; a tick in the symbol's own cycle is used at once, so the clear wins over the set
		if (src != SRC_ISO_PULSE) begin
			next_st.pulse_pending = 1'b0;
		end else if (i_meter_tick) begin
			next_st.pulse_pending = 1'b1;
		end
		if (i_sym_en) begin
			case (src)
				SRC_ISO_PULSE: begin
					if (cur.pulse_pending || i_meter_tick) begin
						next_st.quat = quat_map(iso_level[1], iso_level[0]);
						next_st.pulse_pending = 1'b0;
					end else begin
						next_st.quat = QUAT_ZERO;
					end
				end
				SRC_CU_PLAIN: next_st.quat = quat_map(i_cu_sign, i_cu_mag);
				SRC_CU_2LVL: next_st.quat = quat_map(i_cu_sign, 1'b0);
				SRC_ONES_SCR2: begin
					next_st.quat = quat_map(scr_out_a, 1'b0);
					next_st.lfsr = lfsr_one;
				end
				SRC_LOOP_SCR, SRC_ONES_SCR4, SRC_CU_SCR: begin
					next_st.quat = quat_map(scr_out_a, scr_out_b);
					next_st.lfsr = lfsr_two;
				end
				default: next_st.quat = QUAT_ZERO;
			endcase
			// the scrambler keeps running while silenced so restart needs no resync
			if (tx_off) begin
				next_st.quat = QUAT_ZERO;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cur.mode_reg <= TX_MODE_CONTROL_RESET;
			cur.lfsr <= LFSR_SEED;
			cur.pulse_pending <= 1'b0;
			cur.quat <= QUAT_ZERO;
			cur.quat_valid <= 1'b0;
			cur.rdata <= 8'h00;
		end else begin
			cur <= next_st;
		end
	end

	assign o_reg_rdata = cur.rdata;
	assign o_quat = cur.quat;
	assign o_quat_valid = cur.quat_valid;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);

	sequence s_sym(logic [2:0] m);
		i_sym_en && !tx_off && src == m;
	endsequence

	sequence s_reg_write;
		i_reg_wr && i_reg_addr == TX_MODE_CONTROL_ADDR;
	endsequence

	property p_reg_load;
		s_reg_write |=> cur.mode_reg == ($past(i_reg_wdata) & TX_MODE_CONTROL_WMASK);
	endproperty
	a_reg_load: assert property (p_reg_load) else $error("mode register not loaded");

	property p_off_zero;
		i_sym_en && tx_off |=> o_quat == QUAT_ZERO && o_quat_valid;
	endproperty
	a_off_zero: assert property (p_off_zero) else $error("output not silenced");

	property p_plain4;
		s_sym(SRC_CU_PLAIN) |=> o_quat == quat_map($past(i_cu_sign), $past(i_cu_mag));
	endproperty
	a_plain4: assert property (p_plain4) else $error("unscrambled quat wrong");

	property p_plain2;
		s_sym(SRC_CU_2LVL) |=> o_quat == ($past(i_cu_sign) ? QUAT_P3 : QUAT_M3);
	endproperty
	a_plain2: assert property (p_plain2) else $error("two-level quat wrong");

	property p_ones2_sign;
		s_sym(SRC_ONES_SCR2) |=> (o_quat == QUAT_P3) ==
			(1'b1 ^ $past(cur.lfsr[LEN-1]) ^ ($past(poly_remote) ? $past(cur.lfsr[TAP_REMOTE-1]) :
			$past(cur.lfsr[TAP_LOCAL-1]))) && (o_quat == QUAT_P3 || o_quat == QUAT_M3);
	endproperty
	a_ones2_sign: assert property (p_ones2_sign) else $error("two-level scrambled sign wrong");

	property p_step_once;
		i_sym_en && src == SRC_ONES_SCR2 |=> cur.lfsr[LEN-1:1] == $past(cur.lfsr[LEN-2:0]);
	endproperty
	a_step_once: assert property (p_step_once) else $error("scrambler not stepped once");

	property p_step_twice;
		i_sym_en && (src == SRC_ONES_SCR4 || src == SRC_CU_SCR || src == SRC_LOOP_SCR)
			|=> cur.lfsr[LEN-1:2] == $past(cur.lfsr[LEN-3:0]);
	endproperty
	a_step_twice: assert property (p_step_twice) else $error("scrambler not stepped twice");

	property p_reserved_zero;
		s_sym(SRC_RESERVED) |=> o_quat == QUAT_ZERO;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved source not zero");

	property p_zero_only_iso;
		o_quat_valid && o_quat == QUAT_ZERO |-> $past(tx_off) || $past(src == SRC_ISO_PULSE) ||
			$past(src == SRC_RESERVED);
	endproperty
	a_zero_only_iso: assert property (p_zero_only_iso) else $error("zero level outside pulse mode");

	property p_iso_pulse;
		s_sym(SRC_ISO_PULSE) ##0 (cur.pulse_pending || i_meter_tick)
			|=> o_quat == quat_map($past(iso_level[1]), $past(iso_level[0]))
			##1 (!cur.pulse_pending || $past(i_meter_tick));
	endproperty
	a_iso_pulse: assert property (p_iso_pulse) else $error("isolated pulse missing");

	property p_valid_rate;
		1'b1 |=> o_quat_valid == $past(i_sym_en);
	endproperty
	a_valid_rate: assert property (p_valid_rate) else $error("quat valid missing");
endmodule : tx_symbol_source_scrambler
`default_nettype wire

//--- include/tx_src_pkg.sv
// Purpose: shared constants and helpers for the transmit symbol source and scrambler
// Assumes: one 40 MHz clock, symbol rate given as a one-cycle enable
// Notes: quat codes are 3-bit two's complement levels for the four-level dac
`default_nettype none
package tx_src_pkg;
	// ************************************************************
	// register map and field layout
	// ************************************************************
	localparam logic [7:0] TX_MODE_CONTROL_ADDR = 8'h0B;
	localparam logic [7:0] TX_MODE_CONTROL_RESET = 8'h0A;
	localparam logic [7:0] TX_MODE_CONTROL_WMASK = 8'h7F;
	localparam int SRC_LSB = 0;
	localparam int SRC_MSB = 2;
	localparam int OFF_BIT = 3;
	localparam int POLY_BIT = 4;
	localparam int ISO_LSB = 5;
	localparam int ISO_MSB = 6;

	// ************************************************************
	// source codes
	// ************************************************************
	localparam logic [2:0] SRC_ISO_PULSE = 3'h0;
	localparam logic [2:0] SRC_LOOP_SCR = 3'h1;
	localparam logic [2:0] SRC_CU_PLAIN = 3'h2;
	localparam logic [2:0] SRC_ONES_SCR4 = 3'h3;
	localparam logic [2:0] SRC_RESERVED = 3'h4;
	localparam logic [2:0] SRC_CU_SCR = 3'h5;
	localparam logic [2:0] SRC_CU_2LVL = 3'h6;
	localparam logic [2:0] SRC_ONES_SCR2 = 3'h7;

	// ************************************************************
	// scrambler
	// ************************************************************
	localparam int LFSR_LEN = 23;
	localparam int TAP_LOCAL = 5;
	localparam int TAP_REMOTE = 18;
	localparam logic [22:0] LFSR_SEED = 23'h7FFFFF;

	// ************************************************************
	// dac levels
	// ************************************************************
	localparam logic [2:0] QUAT_ZERO = 3'h0;
	localparam logic [2:0] QUAT_P1 = 3'h1;
	localparam logic [2:0] QUAT_P3 = 3'h3;
	localparam logic [2:0] QUAT_M3 = 3'h5;
	localparam logic [2:0] QUAT_M1 = 3'h7;

	function automatic logic [2:0] quat_map(input logic sign, input logic mag);
		case ({sign, mag})
			2'h0: quat_map = QUAT_M3;
			2'h1: quat_map = QUAT_M1;
			2'h3: quat_map = QUAT_P1;
			default: quat_map = QUAT_P3;
		endcase
	endfunction : quat_map
endpackage : tx_src_pkg
`default_nettype wire

//--- core/tx_scrambler_lfsr.sv
// Purpose: two chained steps of the self-synchronising 23-bit scrambler
// Assumes: state bit 0 holds the most recent output bit
// Notes: purely combinational; the caller owns the register
`default_nettype none
module tx_scrambler_lfsr #(
	parameter int LEN = 23
) (
	input wire logic [LEN-1:0] i_state,
	input wire logic i_remote,
	input wire logic i_bit_a,
	input wire logic i_bit_b,
	output logic o_out_a,
	output logic o_out_b,
	output logic [LEN-1:0] o_state_one,
	output logic [LEN-1:0] o_state_two
);
	import tx_src_pkg::*;

	// one step: output = input xor delay-23 xor selected delay
	function automatic logic scr_bit(input logic [LEN-1:0] s, input logic remote, input logic din);
		scr_bit = din ^ s[LEN-1] ^ (remote ? s[TAP_REMOTE-1] : s[TAP_LOCAL-1]);
	endfunction : scr_bit

	always_comb begin
		o_out_a = scr_bit(i_state, i_remote, i_bit_a);
		o_state_one = {i_state[LEN-2:0], o_out_a};
		o_out_b = scr_bit(o_state_one, i_remote, i_bit_b);
		o_state_two = {o_state_one[LEN-2:0], o_out_b};
	end
endmodule : tx_scrambler_lfsr
`default_nettype wire

//--- bench/tx_cu_model.sv
// Purpose: channel unit and loopback detector stand-in
// Assumes: bits change just after each symbol enable edge
// Notes: a count walks all sign and magnitude pairs; detector bits differ from channel bits
`default_nettype none
module tx_cu_model (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_sym_en,
	output logic o_cu_sign,
	output logic o_cu_mag,
	output logic o_det_sign,
	output logic o_det_mag
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt;
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt <= 3'h0;
		end else if (i_sym_en) begin
			cnt <= cnt + 3'h1;
		end
	end
	assign o_cu_sign = cnt[1];
	assign o_cu_mag = cnt[0];
	assign o_det_sign = cnt[2] ^ cnt[0];
	assign o_det_mag = ~cnt[1];
endmodule : tx_cu_model
`default_nettype wire

//--- bench/tx_symbol_source_scrambler_tb.sv
// Purpose: self-checking bench for the symbol source and scrambler
// Assumes: fixed latencies of one cycle for symbols and registers
// Notes: scrambled modes restart from reset so the reference scrambler starts at the seed
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module tx_symbol_source_scrambler_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tx_src_pkg::*;
	logic clk, srst, sym_en, cu_sign, cu_mag, det_sign, det_mag, tick, wr, qv, cs, cm, ds, dm, b1, b2;
	logic [7:0] addr, wdata, rdata, rd;
	logic [2:0] quat, q;
	logic [22:0] s;
	logic [2:0] srcs [4] = '{SRC_LOOP_SCR, SRC_ONES_SCR4, SRC_CU_SCR, SRC_ONES_SCR2};
	int miscompares = 0;
	int n_compared = 0;
	tx_symbol_source_scrambler DUT (.i_clk(clk), .i_srst(srst), .i_sym_en(sym_en), .i_cu_sign(cu_sign),
		.i_cu_mag(cu_mag), .i_det_sign(det_sign), .i_det_mag(det_mag), .i_meter_tick(tick), .i_reg_wr(wr),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_quat(quat), .o_quat_valid(qv));
	tx_cu_model PART (.i_clk(clk), .i_srst(srst), .i_sym_en(sym_en), .o_cu_sign(cu_sign),
		.o_cu_mag(cu_mag), .o_det_sign(det_sign), .o_det_mag(det_mag));
	function automatic logic [2:0] mp(input logic sg, input logic mg);
		case ({sg, mg})
			2'h0: mp = QUAT_M3;
			2'h1: mp = QUAT_M1;
			2'h3: mp = QUAT_P1;
			default: mp = QUAT_P3;
		endcase
	endfunction : mp
	// new bit shifts into bit 0; reference kept apart from the design's own logic
	function automatic logic scr(input logic b, input logic rem);
		scr = b ^ s[LFSR_LEN-1] ^ (rem ? s[TAP_REMOTE-1] : s[TAP_LOCAL-1]);
		s = {s[21:0], scr};
	endfunction : scr
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test
	task automatic rst();
		@(posedge clk);
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		s = LFSR_SEED;
	endtask : rst
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		repeat (2) @(posedge clk);
		#1 d = rdata;
	endtask : rd_reg
	// partner bits only move on symbol edges, so they are taken settled one cycle before the block samples them
	task automatic sym();
		@(posedge clk);
		sym_en <= 1'b1;
		#1 {cs, cm, ds, dm} = {cu_sign, cu_mag, det_sign, det_mag};
		@(posedge clk);
		sym_en <= 1'b0;
		#1 `CHK("valid", 1'b1, qv)
		q = quat;
	endtask : sym
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		miscompares++;
		end_of_test();
	end
	initial begin
		{srst, sym_en, tick, wr, addr, wdata} = {1'b1, 19'h0};
		rst();
		#1 `CHK("quat_rst", QUAT_ZERO, quat)
		`CHK("valid_rst", 1'b0, qv)
		rd_reg(TX_MODE_CONTROL_ADDR, rd);
		`CHK("reg_rst", TX_MODE_CONTROL_RESET, rd)
		sym();
		`CHK("quat_off", QUAT_ZERO, q)
		wr_reg(8'h0C, 8'h55);
		rd_reg(8'h0C, rd);
		`CHK("unmapped", 8'h00, rd)
		wr_reg(TX_MODE_CONTROL_ADDR, 8'hFF);
		rd_reg(TX_MODE_CONTROL_ADDR, rd);
		`CHK("reg_mask", 8'h7F, rd)
		wr_reg(TX_MODE_CONTROL_ADDR, {5'h00, SRC_CU_PLAIN});
		repeat (4) begin
			sym();
			`CHK("plain", mp(cs, cm), q)
		end
		wr_reg(TX_MODE_CONTROL_ADDR, {5'h00, SRC_CU_2LVL});
		repeat (4) begin
			sym();
			`CHK("two_level", cs ? QUAT_P3 : QUAT_M3, q)
		end
		wr_reg(TX_MODE_CONTROL_ADDR, {5'h00, SRC_RESERVED});
		sym();
		`CHK("reserved", QUAT_ZERO, q)
		for (int l = 0; l < 4; l++) begin
			wr_reg(TX_MODE_CONTROL_ADDR, {1'b0, 2'(l), 2'h0, SRC_ISO_PULSE});
			@(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
			sym();
			`CHK("pulse", mp(l[1], l[0]), q)
			sym();
			`CHK("pulse_gap", QUAT_ZERO, q)
		end
		for (int m = 0; m < 8; m++) begin
			rst();
			wr_reg(TX_MODE_CONTROL_ADDR, {3'h0, m[0], 1'b0, srcs[m/2]});
			// 24 symbols push fed-back bits past both taps and the delay-23 tap
			repeat (24) begin
				sym();
				case (srcs[m/2])
					SRC_LOOP_SCR: {b1, b2} = {ds, dm};
					SRC_CU_SCR: {b1, b2} = {cs, cm};
					default: {b1, b2} = 2'h3;
				endcase
				// separate statements keep sign scrambled before magnitude
				b1 = scr(b1, m[0]);
				if (srcs[m/2] == SRC_ONES_SCR2) begin
					b2 = 1'b0;
				end else begin
					b2 = scr(b2, m[0]);
				end
				`CHK("scrambled", mp(b1, b2), q)
			end
		end
		wr_reg(TX_MODE_CONTROL_ADDR, {5'h01, SRC_CU_SCR});
		sym();
		`CHK("off_scrambled", QUAT_ZERO, q)
		end_of_test();
	end
endmodule : tx_symbol_source_scrambler_tb
`default_nettype wire
